// >>> logic/tbc_timer.sv
// Sixteen-bit capture timer end: registers, counter, capture and events.
// How it works
// - Capture copies counter into compare latch.
// - Network routes lower wrap, shared capture.
// - Lower timer: cascade off, capture mode.
// - Upper timer: cascade on, event clock.
// - Filter passes level after four equal samples.
// - Filter adds four cycles of delay.
// - Filter samples on peripheral clock always.
// - Companion clock choice uses companion tick.
// - Restart with companion when sync set.
// - Event pulses match flag set conditions.
// - Event clock choice counts count-input rising edges.
// - Enabled capture events act per edge/mode.
// - Source holds events one clock minimum.
// - Unsynced_trigger_enable single-shot catches short pulses.
// - Wrap flag set on max-to-zero rollover.
// - Request while flag and enable set.
// - Standby halts unless run-in-standby set.
// - Power-down halts counting and capture; registers stay accessible.
// - Cascade delays capture event one cycle.
// - Clock select decode per code table.
// - At max, wrap event and zero.
`timescale 1ns/1ps
module tbc_timer
   import tbc_pkg::*;
(
   input  wire logic   clk_i,
   input  wire logic   resetn_i,
   tbc_link_if.timer_end link,
   input  wire logic [3:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic   reg_wr_i,
   input  wire logic   reg_rd_i,
   output logic [7:0]  reg_rdata_o,
   output logic        irq_o
);
   logic [7:0]  ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d, event_control_q, event_control_d;
   logic [7:0]  inten_q, inten_d, flags_q, flags_d, dbg_q, dbg_d;
   logic [7:0]  stage_q, stage_d, rdata_q, rdata_d;
   logic [15:0] cnt_q, cnt_d, cmp_q, cmp_d;
   logic        run_q, run_d, div_q, div_d, cnt_ev_q, cnt_ev_d;
   logic        tgl_q, tgl_d, cdly_r_q, cdly_r_d, cdly_f_q, cdly_f_d;
   logic        snapshot_event_out_q, snapshot_event_out_d, wrap_out_q, wrap_out_d, irq_q, irq_d;
   logic        f_rise, f_fall;

   // Field pick used for every mode and clock decision.
   function automatic logic [2:0] fld3(input logic [7:0] r, input int lsb);
      fld3 = r[lsb +: 3];
   endfunction : fld3

   tbc_noise_filter i_tbc_noise_filter (
      .clk_i       (clk_i),
      .resetn_i    (resetn_i),
      .filter_en_i (event_control_q[EV_FILTER]),
      .raw_i       (link.snapshot_event_ev),
      .rise_o      (f_rise),
      .fall_o      (f_fall)
   );

   // Next-state logic for registers, counter and events.
   always_comb
   begin
      logic       active, tick, restart, rise, fall, act, actv, capture, wrap, lo_rd;
      logic [2:0] mode;
      active = 1'b0; tick = 1'b0; restart = 1'b0; rise = 1'b0; fall = 1'b0;
      act = 1'b0; actv = 1'b0; capture = 1'b0; wrap = 1'b0; lo_rd = 1'b0;
      mode = fld3(ctrl_b_q, CB_MODE_LSB);
      ctrl_a_d = ctrl_a_q; ctrl_b_d = ctrl_b_q; event_control_d = event_control_q;
      inten_d = inten_q; flags_d = flags_q; dbg_d = dbg_q; stage_d = stage_q;
      cnt_d = cnt_q; cmp_d = cmp_q; run_d = run_q; rdata_d = rdata_q;
      tgl_d = link.snapshot_event_tgl;
      cnt_ev_d = link.count_ev;
      // Sleep gating: power-down always halts, standby unless allowed to run.
      active = ctrl_a_q[CA_ENABLE] && !link.powerdown
               && !(link.standby && !ctrl_a_q[CA_RUN_IN_STANDBY]);
      div_d = active ? ~div_q : div_q;
      // Count tick from the selected source; reserved codes never count.
      unique case (fld3(ctrl_a_q, CA_CLK_LSB))
         CLK_DIV1:  tick = 1'b1;
         CLK_DIV2:  tick = div_q;
         CLK_COMP0: tick = link.comp_tick[0];
         CLK_COMP1: tick = link.comp_tick[1];
         CLK_EVENT: tick = link.count_ev & ~cnt_ev_q;
         default:   tick = 1'b0;
      endcase
      // Restart follows the companion selected as clock, else companion zero.
      if (fld3(ctrl_a_q, CA_CLK_LSB) == CLK_COMP1)
         restart = ctrl_a_q[CA_RESTART_WITH_COMPANION] & link.comp_restart[1];
      else
         restart = ctrl_a_q[CA_RESTART_WITH_COMPANION] & link.comp_restart[0];
      // The upper timer sees its capture a cycle later so the carry can settle.
      cdly_r_d = f_rise;
      cdly_f_d = f_fall;
      rise = ctrl_a_q[CA_CASCADE] ? cdly_r_q : f_rise;
      fall = ctrl_a_q[CA_CASCADE] ? cdly_f_q : f_fall;
      if (event_control_q[EV_EDGE])
      begin
         act  = fall;
         actv = rise;
      end
      else
      begin
         act  = rise;
         actv = fall;
      end
      // Unsynced_trigger_enable single-shot triggers on any source toggle, even a sub-cycle pulse.
      if (mode == MODE_SINGLE && ctrl_b_q[CB_UNSYNCED_TRIGGER_ENABLE])
         act = link.snapshot_event_tgl ^ tgl_q;
      act  = act & event_control_q[EV_SNAPSHOT_INPUT_ENABLE] & active;
      actv = actv & event_control_q[EV_SNAPSHOT_INPUT_ENABLE] & active;
      if (active)
      begin
         if (tick && run_q)
         begin
            wrap  = (cnt_q == CNT_MAX);
            cnt_d = wrap ? RST_WORD : cnt_q + 16'h0001;
            if (mode == MODE_PERIODIC && cnt_q == cmp_q)
            begin
               capture = 1'b1;
               cnt_d   = RST_WORD;
            end
            if (mode == MODE_SINGLE && cnt_q == cmp_q)
               run_d = 1'b0;
         end
         if (restart)
            cnt_d = RST_WORD;
         unique case (mode)
            MODE_CAPTURE:
               if (act)
               begin
                  cmp_d   = cnt_q;
                  capture = 1'b1;
               end
            MODE_FREQ:
               if (act)
               begin
                  cmp_d   = cnt_q;
                  cnt_d   = RST_WORD;
                  capture = 1'b1;
               end
            MODE_WIDTH, MODE_FRQWID:
               if (act)
                  cnt_d = RST_WORD;
               else if (actv)
               begin
                  cmp_d   = cnt_q;
                  capture = 1'b1;
               end
            MODE_TIMEOUT:
               if (act)
                  run_d = 1'b1;
               else if (actv)
                  run_d = 1'b0;
            MODE_SINGLE:
               if (act && !run_q)
               begin
                  cnt_d = RST_WORD;
                  run_d = 1'b1;
               end
            default: ;
         endcase
      end
      else
      begin
         run_d = 1'b1;
      end
      // Register reads; low bytes snapshot the high byte into staging.
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            ADR_CTRL_A: rdata_d = ctrl_a_q;
            ADR_CTRL_B: rdata_d = ctrl_b_q;
            ADR_EVENT_CONTROL: rdata_d = event_control_q;
            ADR_INTEN:  rdata_d = inten_q;
            ADR_FLAGS:  rdata_d = flags_q;
            ADR_RUNST:  rdata_d = {7'h00, run_q & active};
            ADR_DBG:    rdata_d = dbg_q;
            ADR_STAGE:  rdata_d = stage_q;
            ADR_CNT_L:
            begin
               rdata_d = cnt_q[7:0];
               stage_d = cnt_q[15:8];
            end
            ADR_CMP_L:
            begin
               rdata_d = cmp_q[7:0];
               stage_d = cmp_q[15:8];
               lo_rd   = 1'b1;
            end
            ADR_CNT_H, ADR_CMP_H: rdata_d = stage_q;
            default:    rdata_d = RST_BYTE;
         endcase
      end
      // Register writes; a 16-bit write lands whole on the high byte.
      if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            ADR_CTRL_A: ctrl_a_d = reg_wdata_i & MSK_CTRL_A;
            ADR_CTRL_B: ctrl_b_d = reg_wdata_i & MSK_CTRL_B;
            ADR_EVENT_CONTROL: event_control_d = reg_wdata_i & MSK_EVENT_CONTROL;
            ADR_INTEN:  inten_d  = reg_wdata_i & MSK_FLAGS;
            ADR_FLAGS:  flags_d  = flags_q & ~(reg_wdata_i & MSK_FLAGS);
            ADR_DBG:    dbg_d    = reg_wdata_i & MSK_DBG;
            ADR_STAGE, ADR_CNT_L, ADR_CMP_L: stage_d = reg_wdata_i;
            ADR_CNT_H:  cnt_d    = {reg_wdata_i, stage_q};
            ADR_CMP_H:  cmp_d    = {reg_wdata_i, stage_q};
            default: ;
         endcase
      end
      // Measurement modes clear the capture flag when the low latch byte is read.
      if (lo_rd && (mode == MODE_FREQ || mode == MODE_WIDTH || mode == MODE_FRQWID))
         flags_d[FL_SNAPSHOT_EVENT] = 1'b0;
      // Hardware sets win over a same-cycle clear so no event is lost.
      if (capture)
         flags_d[FL_SNAPSHOT_EVENT] = 1'b1;
      if (wrap)
         flags_d[FL_WRAP] = 1'b1;
      snapshot_event_out_d = capture;
      wrap_out_d = wrap;
      irq_d = |(flags_d & inten_d);
   end

   // State registers.
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ctrl_a_q <= RST_BYTE; ctrl_b_q <= RST_BYTE; event_control_q <= RST_BYTE;
         inten_q <= RST_BYTE; flags_q <= RST_BYTE; dbg_q <= RST_BYTE;
         stage_q <= RST_BYTE; rdata_q <= RST_BYTE;
         cnt_q <= RST_WORD; cmp_q <= RST_WORD;
         run_q <= 1'b0; div_q <= 1'b0; cnt_ev_q <= 1'b0; tgl_q <= 1'b0;
         cdly_r_q <= 1'b0; cdly_f_q <= 1'b0;
         snapshot_event_out_q <= 1'b0; wrap_out_q <= 1'b0; irq_q <= 1'b0;
      end
      else
      begin
         ctrl_a_q <= ctrl_a_d; ctrl_b_q <= ctrl_b_d; event_control_q <= event_control_d;
         inten_q <= inten_d; flags_q <= flags_d; dbg_q <= dbg_d;
         stage_q <= stage_d; rdata_q <= rdata_d;
         cnt_q <= cnt_d; cmp_q <= cmp_d;
         run_q <= run_d; div_q <= div_d; cnt_ev_q <= cnt_ev_d; tgl_q <= tgl_d;
         cdly_r_q <= cdly_r_d; cdly_f_q <= cdly_f_d;
         snapshot_event_out_q <= snapshot_event_out_d; wrap_out_q <= wrap_out_d; irq_q <= irq_d;
      end
   end

   assign link.snapshot_event_out = snapshot_event_out_q;
   assign link.wrap_out = wrap_out_q;
   assign reg_rdata_o   = rdata_q;
   assign irq_o         = irq_q;
endmodule : tbc_timer

// >>> logic/tbc_pkg.sv
// Shared constants for the cascadable capture timer and its event network.
package tbc_pkg;
   // Register offsets.
   localparam logic [3:0] ADR_CTRL_A = 4'h0;
   localparam logic [3:0] ADR_CTRL_B = 4'h1;
   localparam logic [3:0] ADR_EVENT_CONTROL = 4'h4;
   localparam logic [3:0] ADR_INTEN  = 4'h5;
   localparam logic [3:0] ADR_FLAGS  = 4'h6;
   localparam logic [3:0] ADR_RUNST  = 4'h7;
   localparam logic [3:0] ADR_DBG    = 4'h8;
   localparam logic [3:0] ADR_STAGE  = 4'h9;
   localparam logic [3:0] ADR_CNT_L  = 4'ha;
   localparam logic [3:0] ADR_CNT_H  = 4'hb;
   localparam logic [3:0] ADR_CMP_L  = 4'hc;
   localparam logic [3:0] ADR_CMP_H  = 4'hd;
   // Field positions.
   localparam int CA_ENABLE   = 0;
   localparam int CA_CLK_LSB  = 1;
   localparam int CA_RESTART_WITH_COMPANION  = 4;
   localparam int CA_CASCADE  = 5;
   localparam int CA_RUN_IN_STANDBY = 6;
   localparam int CB_MODE_LSB = 0;
   localparam int CB_UNSYNCED_TRIGGER_ENABLE    = 6;
   localparam int EV_SNAPSHOT_INPUT_ENABLE   = 0;
   localparam int EV_EDGE     = 4;
   localparam int EV_FILTER   = 6;
   localparam int FL_SNAPSHOT_EVENT     = 0;
   localparam int FL_WRAP     = 1;
   // Writable bits of each control register; the rest read as zero.
   localparam logic [7:0] MSK_CTRL_A = 8'h7f;
   localparam logic [7:0] MSK_CTRL_B = 8'h77;
   localparam logic [7:0] MSK_EVENT_CONTROL = 8'h51;
   localparam logic [7:0] MSK_FLAGS  = 8'h03;
   localparam logic [7:0] MSK_DBG    = 8'h01;
   // Clock source codes.
   localparam logic [2:0] CLK_DIV1  = 3'h0;
   localparam logic [2:0] CLK_DIV2  = 3'h1;
   localparam logic [2:0] CLK_COMP0 = 3'h2;
   localparam logic [2:0] CLK_COMP1 = 3'h3;
   localparam logic [2:0] CLK_EVENT = 3'h7;
   // Timer mode codes.
   localparam logic [2:0] MODE_PERIODIC = 3'h0;
   localparam logic [2:0] MODE_TIMEOUT  = 3'h1;
   localparam logic [2:0] MODE_CAPTURE  = 3'h2;
   localparam logic [2:0] MODE_FREQ     = 3'h3;
   localparam logic [2:0] MODE_WIDTH    = 3'h4;
   localparam logic [2:0] MODE_FRQWID   = 3'h5;
   localparam logic [2:0] MODE_SINGLE   = 3'h6;
   // Reset values and limits.
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [15:0] CNT_MAX  = 16'hffff;
   localparam int          FILTER_SAMPLES = 4;
endpackage : tbc_pkg

// >>> logic/tbc_link_if.sv
// Link between the timer and the event routing network with companion timers.
`timescale 1ns/1ps
interface tbc_link_if;
   logic       snapshot_event_ev;      // Capture event level from the routing network.
   logic       snapshot_event_tgl;     // Toggles once per capture edge seen at the source.
   logic       count_ev;     // Event count input level.
   logic [1:0] comp_tick;    // Companion timer count clock enables.
   logic [1:0] comp_restart; // Companion timer restart pulses.
   logic       standby;      // Standby sleep level.
   logic       powerdown;    // Power-down sleep level.
   logic       snapshot_event_out;     // Capture event out, one-cycle pulse.
   logic       wrap_out;     // Wrap event out, one-cycle pulse.

   modport timer_end (
      input  snapshot_event_ev, snapshot_event_tgl, count_ev, comp_tick, comp_restart, standby, powerdown,
      output snapshot_event_out, wrap_out
   );
   modport net_end (
      output snapshot_event_ev, snapshot_event_tgl, count_ev, comp_tick, comp_restart, standby, powerdown,
      input  snapshot_event_out, wrap_out
   );
endinterface : tbc_link_if

// >>> logic/tbc_noise_filter.sv
// Four-sample noise filter with edge detection for the capture event input.
`timescale 1ns/1ps
module tbc_noise_filter
   import tbc_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic filter_en_i,
   input  wire logic raw_i,
   output logic      rise_o,
   output logic      fall_o
);
   logic [FILTER_SAMPLES-1:0] hist_q, hist_d;
   logic                      lvl_q, lvl_d;
   logic                      prev_q, prev_d;

   // The history runs on the peripheral clock only, so the prescaler never slows it.
   always_comb
   begin
      hist_d = {hist_q[FILTER_SAMPLES-2:0], raw_i};
      lvl_d  = lvl_q;
      if (!filter_en_i)
      begin
         lvl_d = raw_i;
      end
      else if (&hist_q || ~|hist_q)
      begin
         // Judging the four stored samples, not the incoming one, gives the full delay.
         lvl_d = hist_q[0];
      end
      prev_d = lvl_q;
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         hist_q <= '0;
         lvl_q  <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         hist_q <= hist_d;
         lvl_q  <= lvl_d;
         prev_q <= prev_d;
      end
   end

   assign rise_o = lvl_q & ~prev_q;
   assign fall_o = ~lvl_q & prev_q;
endmodule : tbc_noise_filter

// >>> logic/tbc_event_net.sv
// Event routing and companion-timer end that feeds one timer over the link.
`timescale 1ns/1ps
module tbc_event_net
   import tbc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   tbc_link_if.net_end     link,
   input  wire logic       ext_snapshot_event_i,
   input  wire logic       ext_count_i,
   input  wire logic       lower_wrap_i,
   input  wire logic       use_cascade_i,
   input  wire logic [1:0] comp_tick_i,
   input  wire logic [1:0] comp_restart_i,
   input  wire logic       standby_i,
   input  wire logic       powerdown_i,
   output logic            snapshot_event_seen_o,
   output logic            wrap_seen_o
);
   logic       snapshot_event_q, snapshot_event_d, prev_q, prev_d, tgl_q, tgl_d, cnt_q, cnt_d;
   logic       sb_q, sb_d, pd_q, pd_d, cs_q, cs_d, ws_q, ws_d;
   logic [1:0] tick_q, tick_d, rst_q, rst_d;

   // Routing: a cascaded upper timer counts the lower timer's wraps.
   always_comb
   begin
      snapshot_event_d = ext_snapshot_event_i;
      prev_d = ext_snapshot_event_i;
      tgl_d  = tgl_q ^ (ext_snapshot_event_i & ~prev_q);
      cnt_d  = use_cascade_i ? lower_wrap_i : ext_count_i;
      tick_d = comp_tick_i;
      rst_d  = comp_restart_i;
      sb_d   = standby_i;
      pd_d   = powerdown_i;
      cs_d   = link.snapshot_event_out;
      ws_d   = link.wrap_out;
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         snapshot_event_q <= 1'b0; prev_q <= 1'b0; tgl_q <= 1'b0; cnt_q <= 1'b0;
         tick_q <= 2'h0; rst_q <= 2'h0; sb_q <= 1'b0; pd_q <= 1'b0;
         cs_q <= 1'b0; ws_q <= 1'b0;
      end
      else
      begin
         snapshot_event_q <= snapshot_event_d; prev_q <= prev_d; tgl_q <= tgl_d; cnt_q <= cnt_d;
         tick_q <= tick_d; rst_q <= rst_d; sb_q <= sb_d; pd_q <= pd_d;
         cs_q <= cs_d; ws_q <= ws_d;
      end
   end

   assign link.snapshot_event_ev      = snapshot_event_q;
   assign link.snapshot_event_tgl     = tgl_q;
   assign link.count_ev     = cnt_q;
   assign link.comp_tick    = tick_q;
   assign link.comp_restart = rst_q;
   assign link.standby      = sb_q;
   assign link.powerdown    = pd_q;
   assign snapshot_event_seen_o       = cs_q;
   assign wrap_seen_o       = ws_q;
endmodule : tbc_event_net

// >>> testbench/tbc_link_sva.sv
// Checker for the event pulses that the timer sends over its link.
`timescale 1ns/1ps
module tbc_link_sva (
   input wire logic       clk_i,
   input wire logic       resetn_i,
   input wire logic       snapshot_event_ev,
   input wire logic       snapshot_event_tgl,
   input wire logic       count_ev,
   input wire logic [1:0] comp_tick,
   input wire logic [1:0] comp_restart,
   input wire logic       standby,
   input wire logic       powerdown,
   input wire logic       snapshot_event_out,
   input wire logic       wrap_out
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   // Event users downstream count strobes, so a stretched pulse counts twice.
   property p_snapshot_event_pulse;
      snapshot_event_out |=> !snapshot_event_out;
   endproperty
   a_snapshot_event_pulse: assert property (p_snapshot_event_pulse)
      else $error("capture pulse longer than one cycle");
   property p_wrap_pulse;
      wrap_out |=> !wrap_out;
   endproperty
   a_wrap_pulse: assert property (p_wrap_pulse)
      else $error("wrap pulse longer than one cycle");
   // One cycle of grace covers a pulse launched just before the sleep level landed.
   property p_pd_snapshot_event;
      $past(powerdown) |-> !snapshot_event_out;
   endproperty
   a_pd_snapshot_event: assert property (p_pd_snapshot_event)
      else $error("capture pulse during power-down");
   property p_pd_wrap;
      $past(powerdown) && powerdown |-> !wrap_out;
   endproperty
   a_pd_wrap: assert property (p_pd_wrap)
      else $error("wrap pulse during power-down");
   // The toggle record must move exactly when the synchronous capture level rises.
   property p_tgl_edge;
      $changed(snapshot_event_tgl) |-> $rose(snapshot_event_ev);
   endproperty
   a_tgl_edge: assert property (p_tgl_edge)
      else $error("capture toggle moved without a rising capture level");
   property p_tgl_rise;
      $rose(snapshot_event_ev) |-> $changed(snapshot_event_tgl);
   endproperty
   a_tgl_rise: assert property (p_tgl_rise)
      else $error("rising capture level left the toggle unchanged");
   c_snapshot_event: cover property (snapshot_event_out);
endmodule : tbc_link_sva

// >>> testbench/tbc_timer_tb.sv
// Self-checking bench for the timer and its event network joined over the link.
`timescale 1ns/1ps
module tbc_timer_tb;
   import tbc_pkg::*;
   logic       clk = 1'b0;
   logic       resetn = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic       irq;
   logic       ext_snapshot_event = 1'b0;
   logic       ext_count = 1'b0;
   logic [1:0] comp_tick = 2'h0;
   logic [1:0] comp_restart = 2'h0;
   logic       standby = 1'b0;
   logic       powerdown = 1'b0;
   logic       toggle_count = 1'b0;
   logic       pulse_restart = 1'b0;
   logic       use_cascade = 1'b0;
   logic       lower_wrap = 1'b0;
   logic       snapshot_event_seen;
   logic       wrap_seen;
   int         n_snapshot_event_seen = 0;
   int         n_errors = 0;
   int         checked = 0;

   tbc_link_if link ();
   tbc_event_net i_tbc_event_net (.clk_i(clk), .resetn_i(resetn), .link(link),
      .ext_snapshot_event_i(ext_snapshot_event), .ext_count_i(ext_count), .lower_wrap_i(lower_wrap),
      .use_cascade_i(use_cascade), .comp_tick_i(comp_tick), .comp_restart_i(comp_restart),
      .standby_i(standby), .powerdown_i(powerdown), .snapshot_event_seen_o(snapshot_event_seen),
      .wrap_seen_o(wrap_seen));
   tbc_timer i_tbc_timer (.clk_i(clk), .resetn_i(resetn), .link(link),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .irq_o(irq));
   tbc_link_sva i_tbc_link_sva (.clk_i(clk), .resetn_i(resetn), .snapshot_event_ev(link.snapshot_event_ev),
      .snapshot_event_tgl(link.snapshot_event_tgl), .count_ev(link.count_ev), .comp_tick(link.comp_tick),
      .comp_restart(link.comp_restart), .standby(link.standby),
      .powerdown(link.powerdown), .snapshot_event_out(link.snapshot_event_out), .wrap_out(link.wrap_out));

   // Counts capture strobes as the network saw them; a stretched pulse counts twice.
   always @(posedge clk)
   begin
      if (snapshot_event_seen === 1'b1)
         n_snapshot_event_seen <= n_snapshot_event_seen + 1;
   end

   // A 100 MHz clock.
   always #5 clk = ~clk;

   // Verdict in one place, for the main sequence and the watchdog alike.
   task automatic close_out;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // Each access starts on a fresh edge, so strobes never toggle twice in one step.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      @(posedge clk);
      #1;
      d = reg_rdata;
   endtask : rd

   // Cycles from enable until a wrap pulse, starting 16 counts below wrap.
   task automatic time_to_wrap(input logic [7:0] ctrl, output int n);
      wr(ADR_CTRL_A, 8'h00);
      wr(ADR_FLAGS, MSK_FLAGS);
      wr(ADR_CNT_L, 8'hf0);
      wr(ADR_CNT_H, 8'hff);
      wr(ADR_CTRL_A, ctrl);
      n = 0;
      while (n < 60 && link.wrap_out !== 1'b1)
      begin
         @(posedge clk);
         #1;
         n++;
         if (toggle_count) ext_count = ~ext_count;
         if (pulse_restart) comp_restart = (n % 8 == 0) ? 2'h1 : 2'h0;
         if (use_cascade) lower_wrap = ~lower_wrap;
      end
   endtask : time_to_wrap

   // The counter is parked at 0x1234 on a silent companion clock.
   task automatic snapshot_event_lat(input logic [7:0] ev, input logic [7:0] ctrl, input int width,
                           output int n);
      wr(ADR_CTRL_A, 8'h00);
      wr(ADR_FLAGS, MSK_FLAGS);
      wr(ADR_EVENT_CONTROL, ev);
      wr(ADR_CNT_L, 8'h34);
      wr(ADR_CNT_H, 8'h12);
      wr(ADR_CTRL_A, ctrl);
      repeat (6) @(posedge clk);
      #1;
      ext_snapshot_event = 1'b1;
      n = 0;
      while (n < 20 && link.snapshot_event_out !== 1'b1)
      begin
         @(posedge clk);
         #1;
         n++;
         if (n == width) ext_snapshot_event = 1'b0;
      end
      ext_snapshot_event = 1'b0;
      repeat (10) @(posedge clk);
   endtask : snapshot_event_lat

   task automatic t_regs;
      logic [7:0] d;
      rd(ADR_CTRL_A, d);
      chk(d, RST_BYTE, "control_a reset");
      wr(ADR_CTRL_B, 8'hff);
      rd(ADR_CTRL_B, d);
      chk(d, MSK_CTRL_B, "control_b mask");
      wr(ADR_CTRL_B, 8'h00);
      wr(4'h3, 8'h5a);
      rd(4'h3, d);
      chk(d, 8'h00, "unmapped offset");
   endtask : t_regs

   task automatic t_clocks;
      int n;
      logic [7:0] d;
      wr(ADR_CTRL_B, {5'h00, MODE_CAPTURE});
      wr(ADR_INTEN, 8'h02);
      time_to_wrap(8'h01, n);
      chk(8'(n inside {[15:18]}), 8'h01, "full rate wrap");
      chk(8'(irq), 8'h01, "wrap request");
      @(posedge clk);
      #1;
      chk(8'(wrap_seen), 8'h01, "wrap seen by network");
      chk(8'(link.wrap_out), 8'h00, "wrap pulse ended");
      rd(ADR_FLAGS, d);
      chk(d, 8'h02, "wrap flag");
      wr(ADR_FLAGS, 8'h02);
      rd(ADR_FLAGS, d);
      chk(d, 8'h00, "wrap flag cleared");
      chk(8'(irq), 8'h00, "request dropped");
      time_to_wrap(8'h03, n);
      chk(8'(n inside {[30:36]}), 8'h01, "half rate wrap");
      comp_tick = 2'h1;
      time_to_wrap(8'h05, n);
      chk(8'(n inside {[15:20]}), 8'h01, "companion 0 wrap");
      time_to_wrap(8'h07, n);
      chk(8'(n), 8'd60, "companion 1 silent");
      pulse_restart = 1'b1;
      time_to_wrap(8'h15, n);
      chk(8'(n), 8'd60, "restarted with companion");
      pulse_restart = 1'b0;
      comp_restart = 2'h0;
      comp_tick = 2'h0;
      toggle_count = 1'b1;
      time_to_wrap(8'h0f, n);
      chk(8'(n inside {[30:38]}), 8'h01, "event count wrap");
      toggle_count = 1'b0;
      use_cascade = 1'b1;
      time_to_wrap(8'h0f, n);
      chk(8'(n inside {[30:38]}), 8'h01, "cascade count wrap");
      use_cascade = 1'b0;
   endtask : t_clocks

   task automatic t_sleep;
      int n;
      standby = 1'b1;
      time_to_wrap(8'h01, n);
      chk(8'(n), 8'd60, "halted in standby");
      time_to_wrap(8'h41, n);
      chk(8'(n inside {[15:18]}), 8'h01, "runs in standby");
      powerdown = 1'b1;
      time_to_wrap(8'h41, n);
      chk(8'(n), 8'd60, "halted in power-down");
      powerdown = 1'b0;
      standby = 1'b0;
   endtask : t_sleep

   task automatic t_capture;
      int n;
      logic [7:0] d;
      snapshot_event_lat(8'h01, 8'h05, 8, n);
      chk(8'(n), 8'd3, "capture latency");
      rd(ADR_FLAGS, d);
      chk(d, 8'h01, "capture flag with pulse");
      rd(ADR_CMP_L, d);
      chk(d, 8'h34, "latch low");
      rd(ADR_CMP_H, d);
      chk(d, 8'h12, "latch high");
      rd(ADR_CNT_L, d);
      rd(ADR_STAGE, d);
      chk(d, 8'h12, "staged high byte");
      snapshot_event_lat(8'h41, 8'h05, 8, n);
      chk(8'(n), 8'd7, "filtered latency");
      snapshot_event_lat(8'h01, 8'h25, 8, n);
      chk(8'(n), 8'd4, "cascade latency");
      snapshot_event_lat(8'h41, 8'h05, 2, n);
      chk(8'(n), 8'd20, "glitch rejected");
      snapshot_event_lat(8'h00, 8'h05, 8, n);
      chk(8'(n), 8'd20, "input disabled");
      chk(8'(n_snapshot_event_seen), 8'd3, "capture strobes at network");
   endtask : t_capture

   // Reset for three cycles, then the scenarios in turn.
   initial
   begin
      repeat (3) @(posedge clk);
      #1;
      resetn = 1'b1;
      t_regs();
      t_clocks();
      t_sleep();
      t_capture();
      close_out();
   end

   // The whole run takes some 7 us; a hang is cut off well past that.
   initial
   begin
      #100us;
      n_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      close_out();
   end
endmodule : tbc_timer_tb
